/* dv/far_end_tx.sv */
// far end transmitter model: coded words, bit slip, loopback copy
`timescale 1ns/10ps
`default_nettype none
module far_end_tx (
  input wire logic clk_i,
  input wire logic [2:0] kind_i,
  input wire logic [4:0] slip_i,
  input wire logic loop_i,
  output logic [19:0] rx_word_o,
  output logic [19:0] tx_word_o
);
  logic [19:0] cur;
  logic [19:0] prev = 20'h00000;
  logic idle_b = 1'b0;
  logic [39:0] line;
  // coded words; idles alternate so disparity returns to negative
  always_comb begin
    case (kind_i)
      3'h0: cur = idle_b ? 20'h69683 : 20'h6957c;
      3'h1: cur = 20'h15c57;
      3'h2: cur = 20'h695a5;
      3'h3: cur = 20'h1785e;
      3'h5: cur = idle_b ? 20'hada83 : 20'ha257c;
      default: cur = 20'h13c4f;
    endcase
  end
  // one word per clock, launched on the falling edge
  always_ff @(negedge clk_i) begin
    prev <= cur;
    if (kind_i == 3'h0) idle_b <= ~idle_b;
  end
  // late by slip bits; the unused path carries the inverse
  assign line = {cur, prev} >> (6'd20 - {1'b0, slip_i});
  assign rx_word_o = loop_i ? ~line[19:0] : line[19:0];
  assign tx_word_o = loop_i ? line[19:0] : ~line[19:0];
endmodule // far_end_tx
`default_nettype wire

/* dv/rx_decode_link_sync_tb.sv */
// self-checking bench for the receive decode and link sync block
`timescale 1ns/10ps
`default_nettype none
module rx_decode_link_sync_tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic en = 1'b1, lock_n = 1'b1, det_p = 1'b1, det_n = 1'b1, prbs = 1'b0, loop = 1'b0;
  logic [2:0] kind = 3'h4;
  logic [4:0] slip = 5'h00;
  logic [19:0] rxw, txw;
  logic [15:0] data;
  logic v, e, doe, voe, eoe, coe, soe, lnk;
  logic mon = 1'b0;
  int miscompares = 0, check_count = 0, seed = 32'h0aaf, r, j;
  int q[$];
  int seq[] = '{4, 2, 2, 2, 2, 4, 2, 4, 2, 0, 0, 0, 0, 4, 4, 4, 4, 4, 2, 4, 2, 2, 2};
  logic [1:0] st [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h0};
  logic [15:0] dat [6] = '{16'hc5bc, 16'hf7f7, 16'hc5c5, 16'hfefe, 16'h0000, 16'h50bc};
  far_end_tx far_end_tx_i (.clk_i(clk_i), .kind_i(kind), .slip_i(slip), .loop_i(loop),
    .rx_word_o(rxw), .tx_word_o(txw));
  rx_decode_link_sync rx_decode_link_sync_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .rx_serial_word_i(rxw), .tx_serial_word_i(txw), .signal_detect_pos_i(det_p),
    .signal_detect_neg_i(det_n), .enable_i(en), .lock_to_reference_n_i(lock_n),
    .prbs_test_enable_i(prbs), .loopback_enable_i(loop), .rx_data_o(data),
    .rx_data_oe_n_o(doe), .rx_valid_or_signal_lost_o(v), .rx_valid_oe_n_o(voe),
    .rx_error_flag_o(e), .rx_error_oe_n_o(eoe), .rx_clk_oe_n_o(coe),
    .serial_out_oe_n_o(soe), .link_aligned_o(lnk));
  // 25 mhz word clock
  initial forever #20 clk_i = ~clk_i;
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic send(input int kd, input int n);
    repeat (n) begin
      @(negedge clk_i);
      kind <= kd[2:0];
    end
  endtask
  // random kinds, kind 0 idles always in pairs, kind 5 is the second idle form sent singly
  task automatic burst(input int n);
    repeat (n) begin
      r = {$random(seed)} % 5;
      send((r == 4) ? 5 : r, (r == 0) ? 2 : 1);
    end
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // model: each result compared with the word sent three falling edges before
  always @(negedge clk_i) begin
    if (!mon) q.delete();
    else begin
      q.push_back(kind);
      if (q.size() > 2) begin
        j = q.pop_front();
        check("status", {14'h0, v, e}, {14'h0, st[j]});
        if (j != 4) check("data", data, dat[j]);
      end
    end
  end
  // watchdog
  initial begin
    #200000;
    miscompares++;
    print_verdict();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    send(4, 6);
    check("link_reset", {15'h0, lnk}, 16'h0000);
    send(0, 10);
    check("link_idle", {15'h0, lnk}, 16'h0001);
    mon = 1'b1;
    burst(40);
    foreach (seq[i]) begin
      send(seq[i], 1);
      if (i == 12) check("link_check", {15'h0, lnk}, 16'h0001);
      if (i == 19) check("link_lost", {15'h0, lnk}, 16'h0000);
    end
    check("link_data", {15'h0, lnk}, 16'h0001);
    mon = 1'b0;
    slip = 5'h05;
    send(0, 16);
    mon = 1'b1;
    send(0, 6);
    check("link_slip", {15'h0, lnk}, 16'h0001);
    mon = 1'b0;
    loop = 1'b1;
    send(0, 10);
    mon = 1'b1;
    burst(20);
    check("oe_loop", {11'h0, soe, doe, voe, eoe, coe}, 16'h0010);
    mon = 1'b0;
    det_p = 1'b0;
    send(0, 6);
    check("lost", {data[13:0], v, e}, 16'hffff);
    det_p = 1'b1;
    en = 1'b0;
    send(0, 6);
    check("power_down", {12'h0, doe, eoe, soe, v}, 16'h000f);
    det_n = 1'b0;
    send(0, 4);
    check("detect", {15'h0, v}, 16'h0000);
    det_n = 1'b1;
    en = 1'b1;
    lock_n = 1'b0;
    send(0, 6);
    check("lock_float", {12'h0, doe, voe, eoe, coe}, 16'h000f);
    lock_n = 1'b1;
    prbs = 1'b1;
    send(0, 8);
    check("prbs_fail", {15'h0, e}, 16'h0000);
    print_verdict();
  end
endmodule // rx_decode_link_sync_tb
`default_nettype wire

/* hdl/code_group_decoder.sv */
// one 10-bit to 8-bit code group decoder with disparity check
`timescale 1ns/10ps
`default_nettype none
module code_group_decoder (
  input wire logic [9:0] code_i,
  input wire logic rd_i,
  output logic [7:0] byte_o,
  output logic is_control_o,
  output logic code_valid_o,
  output logic rd_o
);
  logic [5:0] six;
  logic [3:0] four;
  logic [4:0] five;
  logic [2:0] three;
  logic five_ok;
  logic four_ok;
  logic alt_seven;
  logic is_k28;
  logic [3:0] ones;
  logic disp_ok;

  // abcdei and fghj, a is the first received bit
  assign six = {code_i[0], code_i[1], code_i[2], code_i[3], code_i[4], code_i[5]};
  assign is_k28 = (six == 6'h0f) || (six == 6'h30);
  assign four = is_k28 && (six == 6'h30) ?
    ~{code_i[6], code_i[7], code_i[8], code_i[9]} :
    {code_i[6], code_i[7], code_i[8], code_i[9]};

  // 6b to 5b lookup
  always_comb begin
    five = 5'h00;
    five_ok = 1'b1;
    case (six)
      6'h27, 6'h18: five = 5'h00;
      6'h1d, 6'h22: five = 5'h01;
      6'h2d, 6'h12: five = 5'h02;
      6'h31: five = 5'h03;
      6'h35, 6'h0a: five = 5'h04;
      6'h29: five = 5'h05;
      6'h19: five = 5'h06;
      6'h38, 6'h07: five = 5'h07;
      6'h39, 6'h06: five = 5'h08;
      6'h25: five = 5'h09;
      6'h15: five = 5'h0a;
      6'h34: five = 5'h0b;
      6'h0d: five = 5'h0c;
      6'h2c: five = 5'h0d;
      6'h1c: five = 5'h0e;
      6'h17, 6'h28: five = 5'h0f;
      6'h1b, 6'h24: five = 5'h10;
      6'h23: five = 5'h11;
      6'h13: five = 5'h12;
      6'h32: five = 5'h13;
      6'h0b: five = 5'h14;
      6'h2a: five = 5'h15;
      6'h1a: five = 5'h16;
      6'h3a, 6'h05: five = 5'h17;
      6'h33, 6'h0c: five = 5'h18;
      6'h26: five = 5'h19;
      6'h16: five = 5'h1a;
      6'h36, 6'h09: five = 5'h1b;
      6'h0e, 6'h0f, 6'h30: five = 5'h1c;
      6'h2e, 6'h11: five = 5'h1d;
      6'h1e, 6'h21: five = 5'h1e;
      6'h2b, 6'h14: five = 5'h1f;
      default: five_ok = 1'b0;
    endcase
  end

  // 4b to 3b lookup
  always_comb begin
    three = 3'h0;
    four_ok = 1'b1;
    alt_seven = 1'b0;
    case (four)
      4'hb, 4'h4: three = 3'h0;
      4'h9: three = 3'h1;
      4'h5: three = 3'h2;
      4'hc, 4'h3: three = 3'h3;
      4'hd, 4'h2: three = 3'h4;
      4'ha: three = 3'h5;
      4'h6: three = 3'h6;
      4'he, 4'h1: three = 3'h7;
      4'h7, 4'h8: begin
        three = 3'h7;
        alt_seven = 1'b1;
      end
      default: four_ok = 1'b0;
    endcase
  end

  // running disparity: a weighted group must oppose the current disparity
  assign ones = 4'($countones(code_i));
  assign disp_ok = (ones == 4'h5) || ((ones == 4'h6) && !rd_i) || ((ones == 4'h4) && rd_i);
  assign rd_o = (ones == 4'h6) ? 1'b1 : ((ones == 4'h4) ? 1'b0 : rd_i);
  assign byte_o = {three, five};
  assign is_control_o = is_k28 || (alt_seven && ((five == 5'h17) || (five == 5'h1b) ||
    (five == 5'h1d) || (five == 5'h1e)));
  assign code_valid_o = five_ok && four_ok && disp_ok;
endmodule // code_group_decoder
`default_nettype wire

/* hdl/rx_decode_link_sync.sv */
// receive word alignment, dual decode, status outputs and link sync
//
// Contract
// - split word, decode each half separately
// - find comma either polarity, set boundary
// - both bytes captured together, word clock
// - stop realigning after aligned comma once linked
// - realign again on loss of sync
// - status pair encodes idle, extend, data, error
// - error propagation shows FEFE on data
// - idle shows control byte, idle byte, 00
// - lost signal drives data, valid and error outputs high
// - disabled: serial out, data, error float
// - disabled: valid pin shows signal detect
// - reset starts sync in acquire state
// - three idle or extend words align link
// - one data or error word aligns link
// - invalid while aligned flags, goes to check
// - four valid codes in check realign
// - three invalid codes in check reacquire
// - lock low floats receive bus pins
// - prbs mode drives error pin low on mismatch
// - bit clock ten times, both edges
// - loopback routes transmit word, floats output
// - first serial bit lands in bit 0
`timescale 1ns/10ps
`default_nettype none
module rx_decode_link_sync #(
  parameter int WORD_WIDTH = rx_link_pkg::WORD_BITS
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [WORD_WIDTH-1:0] rx_serial_word_i,
  input wire logic [WORD_WIDTH-1:0] tx_serial_word_i,
  input wire logic signal_detect_pos_i,
  input wire logic signal_detect_neg_i,
  input wire logic enable_i,
  input wire logic lock_to_reference_n_i,
  input wire logic prbs_test_enable_i,
  input wire logic loopback_enable_i,
  output logic [15:0] rx_data_o,
  output logic rx_data_oe_n_o,
  output logic rx_valid_or_signal_lost_o,
  output logic rx_valid_oe_n_o,
  output logic rx_error_flag_o,
  output logic rx_error_oe_n_o,
  output logic rx_clk_oe_n_o,
  output logic serial_out_oe_n_o,
  output logic link_aligned_o
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // serial word is two code groups shifted on both bit clock edges
  if (WORD_WIDTH != rx_link_pkg::BIT_CLOCK_MULT * rx_link_pkg::EDGES_PER_BIT_CLOCK) begin : g_bad_w
    $error("word width must equal bit clock multiple times edges");
  end
  if (WORD_WIDTH != 2 * rx_link_pkg::CODE_BITS) begin : g_bad_code
    $error("word width must hold exactly two code groups");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic sig_ok;
  logic enable_s;
  logic lock_s;
  logic prbs_s;
  logic loop_s;

  // two flops before any use
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_meta <= rx_link_pkg::PIN_SYNC_RESET;
      pin_sync <= rx_link_pkg::PIN_SYNC_RESET;
    end else begin
      pin_meta <= {loopback_enable_i, prbs_test_enable_i, lock_to_reference_n_i,
        enable_i, signal_detect_neg_i, signal_detect_pos_i};
      pin_sync <= pin_meta;
    end
  end

  assign sig_ok = pin_sync[0] && pin_sync[1];
  assign enable_s = pin_sync[2];
  assign lock_s = pin_sync[3];
  assign prbs_s = pin_sync[4];
  assign loop_s = pin_sync[5];

  // ----------------------------------------------------------------
  // word source and comma search
  // ----------------------------------------------------------------
  logic [WORD_WIDTH-1:0] raw_word;
  logic [WORD_WIDTH-1:0] prev_word;
  logic [2*WORD_WIDTH-1:0] window;
  logic [9:0] comma_hit;
  logic [WORD_WIDTH-1:0] prbs_miss;
  logic [rx_link_pkg::SHIFT_BITS-1:0] shift;
  logic [rx_link_pkg::SHIFT_BITS-1:0] first_hit;
  logic align_en;
  logic aligned_comma;
  logic [WORD_WIDTH-1:0] aligned_word;
  logic prbs_pass;

  // loopback takes the own transmit word
  assign raw_word = loop_s ? tx_serial_word_i : rx_serial_word_i;
  // older word in the low half, earliest bit at bit 0
  assign window = {raw_word, prev_word};

  // two comparator pairs per candidate boundary, one for each code group
  for (genvar k = 0; k < 10; k++) begin : g_comma
    assign comma_hit[k] = (window[k+6:k] == rx_link_pkg::COMMA_POS_PATTERN) ||
      (window[k+6:k] == rx_link_pkg::COMMA_NEG_PATTERN) ||
      (window[k+16:k+10] == rx_link_pkg::COMMA_POS_PATTERN) ||
      (window[k+16:k+10] == rx_link_pkg::COMMA_NEG_PATTERN);
  end

  // self-synchronising check of the seven-stage sequence
  for (genvar i = 0; i < WORD_WIDTH; i++) begin : g_prbs
    assign prbs_miss[i] = window[WORD_WIDTH+i] ^ window[WORD_WIDTH+i-6] ^
      window[WORD_WIDTH+i-7];
  end

  // lowest boundary that shows a comma
  always_comb begin
    first_hit = rx_link_pkg::SHIFT_RESET;
    for (int j = 9; j >= 0; j--) begin
      if (comma_hit[j]) begin
        first_hit = 4'(j);
      end
    end
  end

  assign aligned_comma = comma_hit[shift];

  // ----------------------------------------------------------------
  // alignment register
  // ----------------------------------------------------------------
  logic next_align_en;
  rx_link_pkg::sync_state_type sync_state;
  rx_link_pkg::sync_state_type next_state;

  // realign while searching and until an aligned comma is seen once linked, then lock boundary
  always_comb begin
    next_align_en = align_en;
    if (next_state == rx_link_pkg::acquire_state) begin
      next_align_en = 1'b1;
    end else if (sync_state == rx_link_pkg::aligned_state && aligned_comma) begin
      next_align_en = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      align_en <= rx_link_pkg::ALIGN_EN_RESET;
      shift <= rx_link_pkg::SHIFT_RESET;
    end else begin
      align_en <= next_align_en;
      if (align_en && (|comma_hit) && !aligned_comma) begin
        shift <= first_hit;
      end
    end
  end

  // pipeline stage holding the aligned word
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prev_word <= '0;
      aligned_word <= '0;
      prbs_pass <= 1'b1;
    end else begin
      prev_word <= raw_word;
      aligned_word <= window[shift +: WORD_WIDTH];
      prbs_pass <= ~|prbs_miss;
    end
  end

  // ----------------------------------------------------------------
  // dual decode
  // ----------------------------------------------------------------
  logic rd;
  logic rd_mid;
  logic rd_next;
  logic [7:0] lo_byte;
  logic [7:0] hi_byte;
  logic lo_ctrl;
  logic hi_ctrl;
  logic lo_ok;
  logic hi_ok;

  // first code group feeds the low byte
  code_group_decoder u_dec_lo (
    .code_i(aligned_word[9:0]),
    .rd_i(rd),
    .byte_o(lo_byte),
    .is_control_o(lo_ctrl),
    .code_valid_o(lo_ok),
    .rd_o(rd_mid)
  );
  code_group_decoder u_dec_hi (
    .code_i(aligned_word[19:10]),
    .rd_i(rd_mid),
    .byte_o(hi_byte),
    .is_control_o(hi_ctrl),
    .code_valid_o(hi_ok),
    .rd_o(rd_next)
  );

  // running disparity carried across words
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd <= rx_link_pkg::RD_RESET;
    end else begin
      rd <= rd_next;
    end
  end

  // ----------------------------------------------------------------
  // word classification
  // ----------------------------------------------------------------
  rx_link_pkg::word_class_type word_class;
  logic word_valid;

  // whole word judged at once
  always_comb begin
    word_class = rx_link_pkg::cls_invalid;
    if (lo_ok && hi_ok) begin
      if (lo_ctrl && !hi_ctrl && lo_byte == rx_link_pkg::IDLE_CTRL_BYTE &&
          (hi_byte == rx_link_pkg::IDLE_DATA_BYTE_A ||
          hi_byte == rx_link_pkg::IDLE_DATA_BYTE_B)) begin
        word_class = rx_link_pkg::cls_idle;
      end else if (lo_ctrl && hi_ctrl && lo_byte == rx_link_pkg::CARRIER_EXT_BYTE &&
          hi_byte == rx_link_pkg::CARRIER_EXT_BYTE) begin
        word_class = rx_link_pkg::cls_carrier;
      end else if (lo_ctrl && hi_ctrl && lo_byte == rx_link_pkg::ERR_PROP_BYTE &&
          hi_byte == rx_link_pkg::ERR_PROP_BYTE) begin
        word_class = rx_link_pkg::cls_err_prop;
      end else if (!lo_ctrl && !hi_ctrl) begin
        word_class = rx_link_pkg::cls_data;
      end
    end
  end

  assign word_valid = word_class != rx_link_pkg::cls_invalid;

  // ----------------------------------------------------------------
  // synchronisation state machine
  // ----------------------------------------------------------------
  logic [1:0] idle_cnt;
  logic [2:0] good_cnt;
  logic [1:0] bad_cnt;

  always_comb begin
    next_state = sync_state;
    case (sync_state)
      rx_link_pkg::acquire_state: begin
        if ((word_class == rx_link_pkg::cls_idle || word_class == rx_link_pkg::cls_carrier) &&
            idle_cnt == rx_link_pkg::ACQ_IDLE_COUNT - 2'h1) begin
          next_state = rx_link_pkg::aligned_state;
        end else if (word_class == rx_link_pkg::cls_data ||
            word_class == rx_link_pkg::cls_err_prop) begin
          next_state = rx_link_pkg::aligned_state;
        end
      end
      rx_link_pkg::aligned_state: begin
        if (!word_valid) begin
          next_state = rx_link_pkg::check_state;
        end
      end
      rx_link_pkg::check_state: begin
        if (word_valid && good_cnt == rx_link_pkg::CHECK_GOOD_COUNT - 3'h1) begin
          next_state = rx_link_pkg::aligned_state;
        end else if (!word_valid && bad_cnt == rx_link_pkg::CHECK_BAD_COUNT - 2'h1) begin
          next_state = rx_link_pkg::acquire_state;
        end
      end
      default: next_state = rx_link_pkg::acquire_state;
    endcase
    if (!enable_s) begin
      next_state = rx_link_pkg::acquire_state;
    end
  end

  // state and run counters
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync_state <= rx_link_pkg::acquire_state;
      idle_cnt <= 2'h0;
      good_cnt <= 3'h0;
      bad_cnt <= 2'h0;
    end else begin
      sync_state <= next_state;
      if (next_state != sync_state) begin
        idle_cnt <= 2'h0;
        good_cnt <= 3'h0;
        bad_cnt <= (next_state == rx_link_pkg::check_state) ? 2'h1 : 2'h0;
      end else if (sync_state == rx_link_pkg::acquire_state) begin
        idle_cnt <= (word_class == rx_link_pkg::cls_idle ||
          word_class == rx_link_pkg::cls_carrier) ? idle_cnt + 2'h1 : 2'h0;
      end else if (sync_state == rx_link_pkg::check_state) begin
        good_cnt <= word_valid ? good_cnt + 3'h1 : 3'h0;
        bad_cnt <= word_valid ? bad_cnt : bad_cnt + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // pin enables: disable floats data and error, lock release floats the whole shared bus
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_data_oe_n_o <= 1'b1;
      rx_error_oe_n_o <= 1'b1;
      rx_valid_oe_n_o <= 1'b1;
      rx_clk_oe_n_o <= 1'b1;
      serial_out_oe_n_o <= 1'b1;
      link_aligned_o <= 1'b0;
    end else begin
      rx_data_oe_n_o <= !enable_s || !lock_s;
      rx_error_oe_n_o <= !enable_s || !lock_s;
      rx_valid_oe_n_o <= !lock_s;
      rx_clk_oe_n_o <= !lock_s;
      serial_out_oe_n_o <= !enable_s || loop_s;
      link_aligned_o <= sync_state != rx_link_pkg::acquire_state;
    end
  end

  // data and status pair
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_data_o <= '0;
      rx_valid_or_signal_lost_o <= 1'b0;
      rx_error_flag_o <= 1'b0;
    end else if (!enable_s) begin
      rx_valid_or_signal_lost_o <= sig_ok;
    end else if (!sig_ok) begin
      rx_data_o <= rx_link_pkg::SIGNAL_LOST_WORD;
      rx_valid_or_signal_lost_o <= 1'b1;
      rx_error_flag_o <= 1'b1;
    end else begin
      rx_data_o <= {hi_byte, lo_byte};
      rx_valid_or_signal_lost_o <= word_class == rx_link_pkg::cls_data ||
        !word_valid || word_class == rx_link_pkg::cls_err_prop;
      rx_error_flag_o <= prbs_s ? prbs_pass : (word_class != rx_link_pkg::cls_data &&
        word_class != rx_link_pkg::cls_idle);
      if (word_class == rx_link_pkg::cls_err_prop) begin
        rx_data_o <= rx_link_pkg::ERR_PROP_WORD;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  logic live;
  assign live = enable_s && sig_ok && !prbs_s;

  a_acq_three_idle: assert property (
    sync_state == rx_link_pkg::acquire_state && live && $stable(enable_s) &&
    word_class == rx_link_pkg::cls_idle && idle_cnt == 2'h2
    |=> sync_state == rx_link_pkg::aligned_state)
    else $error("three idles did not align link");
  a_acq_data_jump: assert property (
    sync_state == rx_link_pkg::acquire_state && enable_s && word_class == rx_link_pkg::cls_data
    |=> sync_state == rx_link_pkg::aligned_state)
    else $error("data word did not align link");
  a_aligned_invalid: assert property (
    sync_state == rx_link_pkg::aligned_state && enable_s && !word_valid && live
    |=> sync_state == rx_link_pkg::check_state && rx_valid_or_signal_lost_o && rx_error_flag_o)
    else $error("invalid word not flagged or not checked");
  a_check_recover: assert property (
    sync_state == rx_link_pkg::check_state && enable_s && word_valid && good_cnt == 3'h3
    |=> sync_state == rx_link_pkg::aligned_state)
    else $error("four valid words did not realign");
  a_check_loss: assert property (
    sync_state == rx_link_pkg::check_state && !word_valid && bad_cnt == 2'h2
    |=> sync_state == rx_link_pkg::acquire_state && align_en)
    else $error("third invalid word did not reacquire");
  a_err_prop_word: assert property (
    live && word_class == rx_link_pkg::cls_err_prop
    |=> rx_data_o == 16'hfefe && rx_valid_or_signal_lost_o && rx_error_flag_o)
    else $error("error propagation word wrong");
  a_idle_status: assert property (
    live && word_class == rx_link_pkg::cls_idle
    |=> rx_data_o[7:0] == 8'hbc && !rx_valid_or_signal_lost_o && !rx_error_flag_o)
    else $error("idle word shown wrongly");
  a_carrier_status: assert property (
    live && word_class == rx_link_pkg::cls_carrier
    |=> !rx_valid_or_signal_lost_o && rx_error_flag_o)
    else $error("carrier extend status wrong");
  a_signal_lost: assert property (
    enable_s && !sig_ok
    |=> rx_data_o == 16'hffff && rx_valid_or_signal_lost_o && rx_error_flag_o)
    else $error("signal loss not driven high");
  a_powerdown_float: assert property (
    !enable_s |=> rx_data_oe_n_o && rx_error_oe_n_o && serial_out_oe_n_o &&
    rx_valid_or_signal_lost_o == $past(sig_ok))
    else $error("power down pins wrong");
  a_lock_float: assert property (
    !lock_s |=> rx_data_oe_n_o && rx_valid_oe_n_o && rx_error_oe_n_o && rx_clk_oe_n_o)
    else $error("lock release did not float bus");
  a_boundary_held: assert property (
    !align_en && !(next_state == rx_link_pkg::acquire_state) |=> $stable(shift))
    else $error("boundary moved while realignment off");
endmodule // rx_decode_link_sync
`default_nettype wire

/* shared/rx_link_pkg.sv */
// constants and types shared by the receive decode and link sync logic
package rx_link_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 20;
  localparam int CODE_BITS = 10;
  localparam int BYTE_BITS = 8;
  localparam int DATA_BITS = 16;
  localparam int BIT_CLOCK_MULT = 10;
  localparam int EDGES_PER_BIT_CLOCK = 2;
  localparam int SHIFT_BITS = 4;
  // ----------------------------------------------------------------
  // comma patterns, first received bit in bit 0
  // ----------------------------------------------------------------
  localparam logic [6:0] COMMA_POS_PATTERN = 7'h7c;
  localparam logic [6:0] COMMA_NEG_PATTERN = 7'h03;
  // ----------------------------------------------------------------
  // decoded byte values
  // ----------------------------------------------------------------
  localparam logic [7:0] IDLE_CTRL_BYTE = 8'hbc;
  localparam logic [7:0] IDLE_DATA_BYTE_A = 8'hc5;
  localparam logic [7:0] IDLE_DATA_BYTE_B = 8'h50;
  localparam logic [7:0] CARRIER_EXT_BYTE = 8'hf7;
  localparam logic [7:0] ERR_PROP_BYTE = 8'hfe;
  localparam logic [15:0] ERR_PROP_WORD = 16'hfefe;
  localparam logic [15:0] SIGNAL_LOST_WORD = 16'hffff;
  // ----------------------------------------------------------------
  // sync counts
  // ----------------------------------------------------------------
  localparam logic [1:0] ACQ_IDLE_COUNT = 2'h3;
  localparam logic [2:0] CHECK_GOOD_COUNT = 3'h4;
  localparam logic [1:0] CHECK_BAD_COUNT = 2'h3;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic ALIGN_EN_RESET = 1'h1;
  localparam logic [SHIFT_BITS-1:0] SHIFT_RESET = 4'h0;
  localparam logic RD_RESET = 1'h0;
  localparam logic [5:0] PIN_SYNC_RESET = 6'h04;
  // ----------------------------------------------------------------
  // state and word class
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    acquire_state = 3'b001,
    aligned_state = 3'b010,
    check_state = 3'b100
  } sync_state_type;
  typedef enum logic [4:0] {
    cls_idle = 5'b00001,
    cls_carrier = 5'b00010,
    cls_data = 5'b00100,
    cls_err_prop = 5'b01000,
    cls_invalid = 5'b10000
  } word_class_type;
endpackage
